// ==== rtl/address_generator_unit.v ====
// Summary of operation
// - Separate X and Y generators compute addresses independently.
// - Y generator only makes word read addresses for dual-operand MAC class.
// - Linear and circular addressing apply to data and program space.
// - Bit-reversed addressing never applies to program-space addresses.
// - File-register direct takes a 13-bit field into the near region.
// - File-register direct uses the instruction's explicit address.
// - File-register forms use working register zero as implicit operand.
// - Result goes to the file register or default register; multiply writes pair.
// - Move instruction file address reaches the whole data space.
// - Register direct accesses the working register with no memory access.
// - Register indirect uses pointer value unchanged as address.
// - Post-modify uses pointer as address, then adjusts and writes back.
// - Pre-modify adds signed constant, uses and writes back the result.
// - Register offset address is pointer plus base working register.
// - Literal offset address is pointer plus instruction literal.
// - Three-operand first operand is always a base register, direct.
// - Second operand is a register, memory, or 5-bit literal.
// - Result goes to a working register or an effective address.
// - MCU forms allow direct, indirect, post, pre, 5/10-bit literals.
// - Pointer-select all ones disables circular addressing on that side.
// - X circular needs select not all ones and enable bit set.
`include "agu_consts.vh"

module address_generator_unit #(
  parameter AW = 16
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          clk_en,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [15:0]   paddr,
  input  wire [31:0]   pwdata,
  output wire [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire          x_req,
  input  wire [2:0]    x_mode,
  input  wire [3:0]    x_ptr_sel,
  input  wire [AW-1:0] x_ptr_val,
  input  wire [AW-1:0] x_base_val,
  input  wire [AW-1:0] x_offset,
  input  wire [12:0]   x_file_addr,
  input  wire [AW-1:0] x_move_addr,
  input  wire          x_is_move,
  input  wire          x_is_write,
  input  wire          x_prog_space,
  input  wire [9:0]    x_literal,
  input  wire          x_lit_long,
  input  wire [1:0]    x_src2,
  input  wire          x_is_mul,
  input  wire          y_req,
  input  wire          y_is_mac,
  input  wire [2:0]    y_mode,
  input  wire [3:0]    y_ptr_sel,
  input  wire [AW-1:0] y_ptr_val,
  input  wire [AW-1:0] y_base_val,
  input  wire [AW-1:0] y_offset,
  output reg  [AW-1:0] x_ea_q,
  output reg           x_mem_q,
  output reg           x_valid_q,
  output reg           x_circ_q,
  output reg           x_rev_ok_q,
  output reg  [3:0]    x_opnd_reg_q,
  output reg  [AW-1:0] x_literal_q,
  output reg           x_pair_q,
  output reg           x_wb_q,
  output reg  [3:0]    x_wb_reg_q,
  output reg  [AW-1:0] x_wb_val_q,
  output reg  [AW-1:0] y_ea_q,
  output reg           y_valid_q,
  output reg           y_circ_q,
  output reg           y_wb_q,
  output reg  [3:0]    y_wb_reg_q,
  output reg  [AW-1:0] y_wb_val_q
);

  reg  [15:0] ctrl_q;
  reg  [15:0] xstart_q;
  reg  [15:0] xend_q;
  reg  [15:0] ystart_q;
  reg  [15:0] yend_q;
  reg  [15:0] xcnt_q;
  reg  [15:0] ycnt_q;
  reg  [31:0] rdata;
  reg         hit;

  wire        acc = psel & penable & clk_en;
  wire        wr  = acc & pwrite;
  wire [3:0]  xsel = ctrl_q[`XSEL_LSB+3:`XSEL_LSB];
  wire [3:0]  ysel = ctrl_q[`YSEL_LSB+3:`YSEL_LSB];
  wire        x_circ_on = (xsel != `SEL_NONE) & ctrl_q[`XCEN_BIT];
  wire        y_circ_on = (ysel != `SEL_NONE) & ctrl_q[`YCEN_BIT];

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = rdata;

  always @* begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL:   rdata = {16'h0000, ctrl_q};
      `OFS_XSTART: rdata = {16'h0000, xstart_q};
      `OFS_XEND:   rdata = {16'h0000, xend_q};
      `OFS_YSTART: rdata = {16'h0000, ystart_q};
      `OFS_YEND:   rdata = {16'h0000, yend_q};
      `OFS_STATUS: rdata = {ycnt_q, xcnt_q};
      default:     hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= `CTRL_RESET;
      xstart_q <= `ADDR_RESET;
      xend_q   <= `ADDR_RESET;
      ystart_q <= `ADDR_RESET;
      yend_q   <= `ADDR_RESET;
    end else if (wr && hit) begin
      case (paddr)
        `OFS_CTRL:   ctrl_q   <= pwdata[15:0] & `CTRL_MASK;
        `OFS_XSTART: xstart_q <= pwdata[15:0];
        `OFS_XEND:   xend_q   <= pwdata[15:0];
        `OFS_YSTART: ystart_q <= pwdata[15:0] & `START_MASK;
        `OFS_YEND:   yend_q   <= pwdata[15:0];
        default:     ctrl_q   <= ctrl_q;
      endcase
    end
  end

  // X generator, combinational
  reg  [AW-1:0] xa;
  reg  [AW-1:0] xw;
  reg           xmem;
  reg           xwb;
  reg           xcirc;
  reg  [3:0]    xopnd;
  reg  [AW-1:0] xlit;
  wire          xsel_hit = x_circ_on & (x_ptr_sel == xsel);
  wire [AW-1:0] xpost = x_ptr_val + x_offset;
  wire [AW-1:0] xidx  = x_ptr_val + x_base_val;
  wire [AW-1:0] xpost_c;
  wire [AW-1:0] xidx_c;

  // Modified and offset sums share one correction each
  circ_wrap #(.AW(AW)) xpost_wrap (
    .addr  (xpost),
    .start (xstart_q),
    .stop  (xend_q),
    .on    (xsel_hit),
    .fixed (xpost_c)
  );

  circ_wrap #(.AW(AW)) xidx_wrap (
    .addr  (xidx),
    .start (xstart_q),
    .stop  (xend_q),
    .on    (xsel_hit),
    .fixed (xidx_c)
  );

  always @* begin
    xa    = x_ptr_val;
    xw    = x_ptr_val;
    xmem  = 1'b1;
    xwb   = 1'b0;
    xcirc = 1'b0;
    xopnd = x_ptr_sel;
    xlit  = {AW{1'b0}};
    case (x_mode)
      `MODE_FILE: begin
        xopnd = `DEFAULT_DEFAULT_WORKING_REGISTER;
        if (x_is_move)
          xa = x_move_addr;
        else
          xa = {{(AW-13){1'b0}}, x_file_addr} & `NEAR_MASK;
      end
      `MODE_REG: begin
        xmem = 1'b0;
      end
      `MODE_IND: begin
        // Plain indirect never corrects the pointer
        xa    = x_ptr_val;
        xcirc = xsel_hit;
      end
      `MODE_POST: begin
        xa    = x_ptr_val;
        xw    = xpost_c;
        xwb   = 1'b1;
        xcirc = xsel_hit;
      end
      `MODE_PRE: begin
        xa    = xpost_c;
        xw    = xa;
        xwb   = 1'b1;
        xcirc = xsel_hit;
      end
      `MODE_ROFS: begin
        xa    = xidx_c;
        xcirc = xsel_hit;
      end
      `MODE_LOFS: begin
        xa    = xpost_c;
        xcirc = xsel_hit;
      end
      `MODE_LIT: begin
        xmem = 1'b0;
        if (x_lit_long)
          xlit = {{(AW-10){1'b0}}, x_literal};
        else
          xlit = {{(AW-5){1'b0}}, x_literal[4:0]};
      end
      default: xmem = 1'b0;
    endcase
    // A register or memory operand 2 follows the mode; only a literal overrides it
    if (x_src2 == `SRC2_LIT) begin
      xmem = 1'b0;
      xlit = {{(AW-5){1'b0}}, x_literal[4:0]};
    end
  end

  // Y generator: MAC-class word reads only
  reg  [AW-1:0] ya;
  reg  [AW-1:0] yw;
  reg           ywb;
  reg           yok;
  wire          ysel_hit = y_circ_on & (y_ptr_sel == ysel);
  wire [AW-1:0] ypost = y_ptr_val + y_offset;
  wire [AW-1:0] yidx  = y_ptr_val + y_base_val;
  wire [AW-1:0] ypost_c;
  wire [AW-1:0] yidx_c;

  circ_wrap #(.AW(AW)) ypost_wrap (
    .addr  (ypost),
    .start (ystart_q),
    .stop  (yend_q),
    .on    (ysel_hit),
    .fixed (ypost_c)
  );

  circ_wrap #(.AW(AW)) yidx_wrap (
    .addr  (yidx),
    .start (ystart_q),
    .stop  (yend_q),
    .on    (ysel_hit),
    .fixed (yidx_c)
  );

  always @* begin
    ya  = y_ptr_val;
    yw  = y_ptr_val;
    ywb = 1'b0;
    yok = y_req & y_is_mac;
    case (y_mode)
      `MODE_IND:  ya = y_ptr_val;
      `MODE_POST: begin
        yw  = ypost_c;
        ywb = 1'b1;
      end
      `MODE_ROFS: ya = yidx_c;
      default:    yok = 1'b0;
    endcase
    ya = ya & `WORD_MASK;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_ea_q       <= {AW{1'b0}};
      x_mem_q      <= 1'b0;
      x_valid_q    <= 1'b0;
      x_circ_q     <= 1'b0;
      x_rev_ok_q   <= 1'b0;
      x_opnd_reg_q <= 4'h0;
      x_literal_q  <= {AW{1'b0}};
      x_pair_q     <= 1'b0;
      x_wb_q       <= 1'b0;
      x_wb_reg_q   <= 4'h0;
      x_wb_val_q   <= {AW{1'b0}};
      xcnt_q       <= 16'h0000;
    end else if (clk_en) begin
      x_valid_q    <= x_req;
      x_ea_q       <= xa;
      x_mem_q      <= x_req & xmem;
      x_circ_q     <= x_req & xcirc;
      x_rev_ok_q   <= x_req & ~x_prog_space & x_is_write;
      x_opnd_reg_q <= xopnd;
      x_literal_q  <= xlit;
      x_pair_q     <= x_req & x_is_mul & (x_mode == `MODE_FILE);
      x_wb_q       <= x_req & xwb;
      x_wb_reg_q   <= x_ptr_sel;
      x_wb_val_q   <= xw;
      if (x_req)
        xcnt_q <= xcnt_q + 16'h0001;
    end
  end

  // Y keeps its own output stage so neither generator waits on the other
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_ea_q       <= {AW{1'b0}};
      y_valid_q    <= 1'b0;
      y_circ_q     <= 1'b0;
      y_wb_q       <= 1'b0;
      y_wb_reg_q   <= 4'h0;
      y_wb_val_q   <= {AW{1'b0}};
      ycnt_q       <= 16'h0000;
    end else if (clk_en) begin
      y_valid_q    <= yok;
      y_ea_q       <= ya;
      y_circ_q     <= yok & ysel_hit;
      y_wb_q       <= yok & ywb;
      y_wb_reg_q   <= y_ptr_sel;
      y_wb_val_q   <= yw;
      if (yok)
        ycnt_q <= ycnt_q + 16'h0001;
    end
  end

endmodule

// Circular correction of one address against one start and end window
module circ_wrap #(
  parameter AW = 16
) (
  input  wire [AW-1:0] addr,
  input  wire [15:0]   start,
  input  wire [15:0]   stop,
  input  wire          on,
  output reg  [AW-1:0] fixed
);

  wire [AW-1:0] lo  = start[AW-1:0];
  wire [AW-1:0] hi  = stop[AW-1:0];
  wire [AW-1:0] one = {{(AW-1){1'b0}}, 1'b1};

  // Bounds compare as above or below, so a large step still folds back
  always @* begin
    fixed = addr;
    if (on && (addr > hi))
      fixed = lo + (addr - hi) - one;
    else if (on && (addr < lo))
      fixed = hi - (lo - addr) + one;
  end

endmodule

// ==== rtl/agu_consts.vh ====
`ifndef AGU_CONSTS_VH
`define AGU_CONSTS_VH

// Register byte offsets
`define OFS_CTRL        16'h0046
`define OFS_XSTART      16'h0048
`define OFS_XEND        16'h004a
`define OFS_YSTART      16'h004c
`define OFS_YEND        16'h004e
`define OFS_STATUS      16'h0054

// Control register fields
`define XSEL_LSB        0
`define YSEL_LSB        4
`define RSEL_LSB        8
`define XCEN_BIT        15
`define YCEN_BIT        14
`define SEL_NONE        4'hf
`define CTRL_RESET      16'h0000
`define CTRL_MASK       16'hcfff
`define START_MASK      16'hfffe
`define END_MASK        16'hffff
`define ADDR_RESET      16'h0000

// Addressing modes
`define MODE_FILE       3'h0
`define MODE_REG        3'h1
`define MODE_IND        3'h2
`define MODE_POST       3'h3
`define MODE_PRE        3'h4
`define MODE_ROFS       3'h5
`define MODE_LOFS       3'h6
`define MODE_LIT        3'h7

// Operand-2 sources for three-operand forms
`define SRC2_REG        2'h0
`define SRC2_MEM        2'h1
`define SRC2_LIT        2'h2

`define NEAR_MASK       16'h1fff
`define DEFAULT_DEFAULT_WORKING_REGISTER    4'h0
`define WORD_MASK       16'hfffe

`endif

// ==== verification/agu_properties.sv ====
`include "agu_consts.vh"
module agu_properties #(parameter AW = 16) (
  input wire          pclk, presetn, clk_en, x_req, x_is_move, y_req, y_is_mac,
  input wire [2:0]    x_mode,
  input wire [AW-1:0] x_ptr_val, x_base_val, x_offset, x_move_addr, x_ea_q, x_wb_val_q, y_ea_q,
  input wire [12:0]   x_file_addr,
  input wire [3:0]    x_opnd_reg_q,
  input wire          x_mem_q, x_valid_q, x_circ_q, x_wb_q, y_valid_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire          xg = x_req & clk_en;
  wire [AW-1:0] sum_o = x_ptr_val + x_offset;
  wire [AW-1:0] sum_b = x_ptr_val + x_base_val;
  x_answer_a: assert property (xg |=> x_valid_q)
    else $error("x request gave no answer");
  ind_keep_a: assert property (xg && x_mode == `MODE_IND
    |=> x_ea_q == $past(x_ptr_val) && !x_wb_q)
    else $error("indirect address wrong");
  post_mod_a: assert property (xg && x_mode == `MODE_POST
    |=> x_ea_q == $past(x_ptr_val) && x_wb_q && (x_circ_q || x_wb_val_q == $past(sum_o)))
    else $error("post-modify wrong");
  pre_mod_a: assert property (xg && x_mode == `MODE_PRE
    |=> x_wb_q && x_ea_q == x_wb_val_q && (x_circ_q || x_ea_q == $past(sum_o)))
    else $error("pre-modify wrong");
  reg_offset_a: assert property (xg && x_mode == `MODE_ROFS
    |=> !x_wb_q && (x_circ_q || x_ea_q == $past(sum_b)))
    else $error("register offset wrong");
  lit_offset_a: assert property (xg && x_mode == `MODE_LOFS
    |=> !x_wb_q && (x_circ_q || x_ea_q == $past(sum_o)))
    else $error("literal offset wrong");
  file_near_a: assert property (xg && x_mode == `MODE_FILE && !x_is_move
    |=> x_ea_q == {3'h0, $past(x_file_addr)} && x_opnd_reg_q == `DEFAULT_DEFAULT_WORKING_REGISTER)
    else $error("file address wrong");
  move_full_a: assert property (xg && x_mode == `MODE_FILE && x_is_move
    |=> x_ea_q == $past(x_move_addr))
    else $error("move address wrong");
  reg_direct_a: assert property (xg && x_mode == `MODE_REG |=> !x_mem_q)
    else $error("register direct touched memory");
  y_refuse_a: assert property (y_req && clk_en && !y_is_mac |=> !y_valid_q)
    else $error("y served a non-mac request");
  cover property (x_circ_q && x_wb_q);
  cover property (y_valid_q);
  cover property (xg && x_is_move);
endmodule
bind address_generator_unit agu_properties #(.AW(AW)) chk (.*);

// ==== verification/instr_source.sv ====
module instr_source (
  input  wire         pclk,
  output logic        x_req, x_is_move, x_is_write, x_prog_space, x_lit_long, x_is_mul,
  output logic        y_req, y_is_mac,
  output logic [2:0]  x_mode, y_mode,
  output logic [3:0]  x_ptr_sel, y_ptr_sel,
  output logic [15:0] x_ptr_val, x_base_val, x_offset, x_move_addr,
  output logic [15:0] y_ptr_val, y_base_val, y_offset,
  output logic [12:0] x_file_addr,
  output logic [9:0]  x_literal,
  output logic [1:0]  x_src2
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {x_req, x_is_move, x_is_write, x_prog_space, x_lit_long, x_is_mul, y_req, y_is_mac,
    x_mode, y_mode, x_ptr_sel, y_ptr_sel, x_ptr_val, x_base_val, x_offset, x_move_addr,
    y_ptr_val, y_base_val, y_offset, x_file_addr, x_literal, x_src2} = '0;
  // Request stands for one sampling edge only
  task automatic xop(input [2:0] m, input [3:0] s, input [15:0] p, b, o);
    @(posedge pclk);
    {x_req, x_mode, x_ptr_sel, x_ptr_val, x_base_val, x_offset} <= {1'b1, m, s, p, b, o};
    @(posedge pclk);
    x_req <= 1'b0;
  endtask
  task automatic yop(input mac, input [2:0] m, input [15:0] p, o);
    @(posedge pclk);
    {y_req, y_is_mac, y_mode, y_ptr_val, y_offset} <= {1'b1, mac, m, p, o};
    @(posedge pclk);
    y_req <= 1'b0;
  endtask
endmodule

// ==== verification/tb_address_generator_unit.sv ====
`include "agu_consts.vh"
module tb_address_generator_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, q;
  wire  [31:0] prdata;
  wire         pready, pslverr, x_req, x_is_move, x_is_write, x_prog_space, x_lit_long, x_is_mul;
  wire         y_req, y_is_mac, x_mem_q, x_valid_q, x_circ_q, x_rev_ok_q, x_pair_q, x_wb_q;
  wire         y_valid_q, y_circ_q, y_wb_q;
  wire  [2:0]  x_mode, y_mode;
  wire  [3:0]  x_ptr_sel, y_ptr_sel, x_opnd_reg_q, x_wb_reg_q, y_wb_reg_q;
  wire  [15:0] x_ptr_val, x_base_val, x_offset, x_move_addr, y_ptr_val, y_base_val, y_offset;
  wire  [15:0] x_ea_q, x_literal_q, x_wb_val_q, y_ea_q, y_wb_val_q;
  wire  [12:0] x_file_addr;
  wire  [9:0]  x_literal;
  wire  [1:0]  x_src2;
  int          bad_count = 0, compares = 0;
  address_generator_unit DUT (.*);
  instr_source P (.*);
  initial forever #2 pclk = ~pclk;
  task chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task xt(input [2:0] m, input [3:0] s, input [15:0] p, o, ea, input wb, input [15:0] wv);
    P.xop(m, s, p, 16'h0020, o);
    #1;
    chk(x_ea_q, ea, "address");
    chk(x_wb_q, wb, "write-back flag");
    chk(x_mem_q, 1'b1, "memory access");
    if (wb) chk(x_wb_val_q, wv, "write-back value");
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFS_CTRL, 0); chk(q, 32'h0, "control reset");
    apb(1, `OFS_XSTART, 32'h0000_0100);
    apb(1, `OFS_XEND, 32'h0000_010f);
    apb(1, `OFS_CTRL, 32'hffff_ffff);
    apb(0, `OFS_CTRL, 0); chk(q, {16'h0, `CTRL_MASK}, "control mask");
    apb(1, `OFS_YSTART, 32'h0000_1235);
    apb(0, `OFS_YSTART, 0); chk(q, 32'h0000_1234, "y start word");
    apb(0, 16'h0060, 0); chk(q, 32'h0, "unmapped read");
    clk_en <= 1'b0;
    apb(1, `OFS_XEND, 32'h0000_0055);
    clk_en <= 1'b1;
    apb(0, `OFS_XEND, 0); chk(q, 32'h0000_010f, "frozen write");
    $display("test registers done");
    @(posedge pclk) {P.x_file_addr, P.x_move_addr} <= {13'h1abc, 16'habcd};
    xt(`MODE_IND, 4'h1, 16'h0100, 16'hfffe, 16'h0100, 0, 0);
    xt(`MODE_POST, 4'h1, 16'h0100, 16'hfffe, 16'h0100, 1, 16'h00fe);
    xt(`MODE_PRE, 4'h1, 16'h0100, 16'hfffe, 16'h00fe, 1, 16'h00fe);
    xt(`MODE_ROFS, 4'h1, 16'h0100, 16'hfffe, 16'h0120, 0, 0);
    xt(`MODE_LOFS, 4'h1, 16'h0100, 16'hfffe, 16'h00fe, 0, 0);
    xt(`MODE_FILE, 4'h1, 16'h0100, 16'hfffe, 16'h1abc, 0, 0);
    chk(x_opnd_reg_q, `DEFAULT_DEFAULT_WORKING_REGISTER, "implicit register");
    @(posedge pclk) {P.x_is_move, P.x_is_mul} <= 2'b01;
    xt(`MODE_FILE, 4'h1, 16'h0100, 16'hfffe, 16'h1abc, 0, 0);
    chk(x_pair_q, 1'b1, "multiply pair");
    @(posedge pclk) {P.x_is_move, P.x_is_mul} <= 2'b10;
    xt(`MODE_FILE, 4'h1, 16'h0100, 16'hfffe, 16'habcd, 0, 0);
    P.xop(`MODE_REG, 4'h1, 16'h0100, 16'h0020, 16'h0000);
    #1 chk(x_mem_q, 1'b0, "register direct");
    $display("test modes done");
    @(posedge pclk) {P.x_literal, P.x_lit_long, P.x_is_write} <= {10'h2a5, 2'b11};
    P.xop(`MODE_LIT, 4'h1, 16'h0, 16'h0, 16'h0);
    #1 chk(x_literal_q, 16'h02a5, "long literal");
    chk(x_rev_ok_q, 1'b1, "reverse on data");
    @(posedge pclk) {P.x_lit_long, P.x_prog_space} <= 2'b01;
    P.xop(`MODE_LIT, 4'h1, 16'h0, 16'h0, 16'h0);
    #1 chk(x_literal_q, 16'h0005, "short literal");
    chk(x_rev_ok_q, 1'b0, "reverse on program");
    P.yop(0, `MODE_IND, 16'h0200, 16'h0);
    #1 chk(y_valid_q, 1'b0, "y non-mac");
    P.yop(1, `MODE_POST, 16'h0201, 16'h0002);
    #1 chk(y_valid_q, 1'b1, "y mac");
    chk(y_ea_q, 16'h0200, "y word address");
    $display("test literals and y done");
    xt(`MODE_POST, 4'hf, 16'h010e, 16'h0004, 16'h010e, 1, 16'h0112);
    apb(1, `OFS_CTRL, 32'h0000_0002);
    xt(`MODE_POST, 4'h2, 16'h010e, 16'h0004, 16'h010e, 1, 16'h0112);
    apb(1, `OFS_CTRL, 32'h0000_8002);
    xt(`MODE_POST, 4'h2, 16'h010e, 16'h0004, 16'h010e, 1, 16'h0102);
    chk(x_circ_q, 1'b1, "circular flag");
    $display("test circular done");
    summarize;
  end
endmodule
